// ---- logic/vsid_pkg.sv ----
// constants, field layouts and carrier types of the source id decoder
package vsid_pkg;
    localparam int CLK_PERIOD_NS  = 100;
    localparam int NS_PER_US      = 1000;
    localparam int CYC_PER_US     = NS_PER_US / CLK_PERIOD_NS;
    localparam int PULSE_US       = 1;
    localparam int CELL_US        = 2;
    localparam int START_DEF_US   = 26;
    localparam int START_MIN_US   = 26;
    localparam int START_MAX_US   = 52;
    localparam int STOP_END_US    = 57;
    localparam int ID_LINE_DEF    = 16;
    localparam int ID_BITS        = 14;
    localparam int ID_MAX         = 16383;
    localparam int LABEL_CHARS    = 20;
    localparam int LABEL_W        = LABEL_CHARS * 8;
    localparam int LINE_W         = 10;
    localparam int US_W           = 6;
    localparam int CYC_W          = 10;
    localparam int SLICE_LAT      = 1;
    localparam int PULSE_CYC      = PULSE_US * CYC_PER_US;
    localparam int HALF_PULSE_CYC = (PULSE_CYC + 1) / 2;
    localparam int CELL_CYC       = CELL_US * CYC_PER_US;
    localparam int STOP_CTR_CYC   =
        (STOP_END_US - PULSE_US) * CYC_PER_US + HALF_PULSE_CYC;
    localparam int LINE_END_CYC   = STOP_CTR_CYC + SLICE_LAT;

    typedef logic [LABEL_W-1:0] vsid_label_t;
    typedef logic [ID_BITS-1:0] vsid_num_t;

    localparam vsid_label_t NOT_FOUND_TXT = "Not Found";

    typedef struct packed {
        logic [LINE_W-1:0] id_line;
        logic [US_W-1:0]   start_us;
    } vsid_cfg_s;

    typedef struct packed {
        logic        valid;
        vsid_num_t   number;
        vsid_label_t label;
    } vsid_entry_s;

    typedef struct packed {
        logic        found;
        logic        rejected;
        vsid_num_t   number;
        vsid_label_t label;
    } vsid_result_s;
endpackage

// ---- logic/vsid_level_slicer.sv ----
// registered comparison of a video sample against the blank level plus half the bar amplitude
`timescale 1ns/1ps
module vsid_level_slicer #(
    parameter int SAMPLE_W = 10
) (
    input  wire logic                clock,
    input  wire logic                rstn,
    input  wire logic [SAMPLE_W-1:0] sample,
    input  wire logic [SAMPLE_W-1:0] blank_level,
    input  wire logic [SAMPLE_W-1:0] bar_amp,
    output logic                     above_r
);
    // one extra bit so the threshold cannot wrap near full scale
    wire logic [SAMPLE_W:0] thresh = {1'b0, blank_level} +
                                     {2'b00, bar_amp[SAMPLE_W-1:1]};
    wire logic              above_nxt = {1'b0, sample} > thresh;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            above_r <= 1'b0;
        else
            above_r <= above_nxt;
    end
endmodule // vsid_level_slicer

// ---- logic/vsid_decoder.sv ----
// source id decoder: pulse train slicing, framing checks and label lookup
`timescale 1ns/1ps
module vsid_decoder #(
    parameter int SAMPLE_W = 10,
    parameter int DEPTH    = 64,
    parameter int ADDR_W   = $clog2(DEPTH)
) (
    input  wire logic                  clock,
    input  wire logic                  rstn,
    input  wire logic [SAMPLE_W-1:0]   sample,
    input  wire logic [SAMPLE_W-1:0]   blank_level,
    input  wire logic [SAMPLE_W-1:0]   bar_amp,
    input  wire logic                  hsync_lead,
    input  wire logic [vsid_pkg::LINE_W-1:0] line_num,
    input  wire vsid_pkg::vsid_cfg_s   cfg,
    input  wire logic                  tbl_we,
    input  wire logic [ADDR_W-1:0]     tbl_addr,
    input  wire vsid_pkg::vsid_entry_s tbl_entry,
    output logic                       res_valid_r,
    output vsid_pkg::vsid_result_s     res_r,
    output logic                       busy_r
);
    if (DEPTH < 2 || SAMPLE_W < 2 || ADDR_W != $clog2(DEPTH))
    begin : g_bad_params
        $error("vsid_decoder: unsupported parameters");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_LINE, ST_SEARCH} vsid_state_e;

    localparam logic [vsid_pkg::CYC_W-1:0] LAT_C =
        vsid_pkg::CYC_W'(vsid_pkg::SLICE_LAT);
    localparam logic [vsid_pkg::CYC_W-1:0] HALF_C =
        vsid_pkg::CYC_W'(vsid_pkg::HALF_PULSE_CYC);
    localparam logic [vsid_pkg::CYC_W-1:0] CELL_C =
        vsid_pkg::CYC_W'(vsid_pkg::CELL_CYC);
    localparam logic [vsid_pkg::CYC_W-1:0] STOP_C =
        vsid_pkg::CYC_W'(vsid_pkg::STOP_CTR_CYC);
    localparam logic [vsid_pkg::CYC_W-1:0] END_C =
        vsid_pkg::CYC_W'(vsid_pkg::LINE_END_CYC);
    localparam logic [vsid_pkg::CYC_W-1:0] US_C =
        vsid_pkg::CYC_W'(vsid_pkg::CYC_PER_US);
    localparam logic [vsid_pkg::US_W-1:0] START_DEF =
        vsid_pkg::US_W'(vsid_pkg::START_DEF_US);
    localparam logic [vsid_pkg::US_W-1:0] START_MIN =
        vsid_pkg::US_W'(vsid_pkg::START_MIN_US);
    localparam logic [vsid_pkg::US_W-1:0] START_MAX =
        vsid_pkg::US_W'(vsid_pkg::START_MAX_US);
    localparam logic [vsid_pkg::LINE_W-1:0] LINE_DEF =
        vsid_pkg::LINE_W'(vsid_pkg::ID_LINE_DEF);
    localparam logic [3:0] BITS_C = 4'(vsid_pkg::ID_BITS);

    // number and label table
    vsid_pkg::vsid_num_t   tbl_num [DEPTH];
    vsid_pkg::vsid_label_t tbl_lbl [DEPTH];
    logic [DEPTH-1:0]      tbl_vld_r;

    vsid_state_e               state_r;
    logic [vsid_pkg::CYC_W-1:0] cyc_r;
    logic [vsid_pkg::CYC_W-1:0] next_cell_r;
    logic [3:0]                bit_r;
    vsid_pkg::vsid_num_t       code_r;
    logic                      pre_bad_r;
    logic                      start_ok_r;
    logic                      stop_ok_r;
    logic [ADDR_W-1:0]         idx_r;
    logic                      above;

    vsid_level_slicer #(
        .SAMPLE_W    (SAMPLE_W)
    ) u_slicer (
        .clock       (clock),
        .rstn        (rstn),
        .sample      (sample),
        .blank_level (blank_level),
        .bar_amp     (bar_amp),
        .above_r     (above)
    );

    // out-of-range or odd start settings fall back to the default position
    wire logic start_bad = cfg.start_us < START_MIN ||
                           cfg.start_us > START_MAX || cfg.start_us[0];
    wire logic [vsid_pkg::US_W-1:0] start_us_eff =
        start_bad ? START_DEF : cfg.start_us;
    wire logic [vsid_pkg::LINE_W-1:0] id_line_eff =
        (cfg.id_line == '0) ? LINE_DEF : cfg.id_line;

    // slicer output lags the sample by one clock, hence the LAT_C terms
    wire logic [vsid_pkg::CYC_W-1:0] start_cyc =
        vsid_pkg::CYC_W'(start_us_eff * US_C);
    wire logic [vsid_pkg::CYC_W-1:0] start_ctr = start_cyc + HALF_C + LAT_C;
    wire logic line_go  = hsync_lead && line_num == id_line_eff;
    wire logic in_pre   = cyc_r >= LAT_C && cyc_r < start_cyc + LAT_C;
    wire logic at_start = cyc_r == start_ctr;
    wire logic at_stop  = cyc_r == STOP_C + LAT_C;
    // a cell counts only if it ends before the stop pulse starts
    wire logic at_cell  = start_ok_r && cyc_r == next_cell_r &&
                          next_cell_r < STOP_C + LAT_C - CELL_C + US_C &&
                          bit_r < BITS_C;
    // the stop verdict is registered at END_C, so judge the line one later
    wire logic line_end = cyc_r == END_C + LAT_C;
    wire logic code_ok  = start_ok_r && stop_ok_r;
    wire logic hit      = tbl_vld_r[idx_r] && tbl_num[idx_r] == code_r;
    wire logic last_idx = idx_r == ADDR_W'(DEPTH - 1);

    always_ff @(posedge clock)
    begin
        if (tbl_we)
        begin
            tbl_num[tbl_addr] <= tbl_entry.number;
            tbl_lbl[tbl_addr] <= tbl_entry.label;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            tbl_vld_r <= '0;
        else if (tbl_we)
            tbl_vld_r[tbl_addr] <= tbl_entry.valid;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            state_r <= ST_IDLE;
        else
        begin
            case (state_r)
                ST_IDLE:
                    if (line_go)
                        state_r <= ST_LINE;
                ST_LINE:
                    if (line_end)
                        state_r <= (code_ok && !pre_bad_r) ? ST_SEARCH
                                                            : ST_IDLE;
                ST_SEARCH:
                    if (hit || last_idx)
                        state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // line timing and bit capture
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cyc_r       <= '0;
            next_cell_r <= '0;
            bit_r       <= '0;
            code_r      <= '0;
            pre_bad_r   <= 1'b0;
            start_ok_r  <= 1'b0;
            stop_ok_r   <= 1'b0;
        end
        else if (state_r == ST_IDLE)
        begin
            // start at the slicer latency: cyc then equals sample index + 1
            cyc_r      <= LAT_C;
            bit_r      <= '0;
            code_r     <= '0;
            pre_bad_r  <= 1'b0;
            start_ok_r <= 1'b0;
            stop_ok_r  <= 1'b0;
        end
        else if (state_r == ST_LINE)
        begin
            cyc_r <= cyc_r + 1'b1;
            if (in_pre && above)
                pre_bad_r <= 1'b1;
            if (at_start)
            begin
                start_ok_r  <= above;
                next_cell_r <= cyc_r + CELL_C;
            end
            if (at_cell)
            begin
                code_r[bit_r] <= above;
                bit_r         <= bit_r + 1'b1;
                next_cell_r   <= next_cell_r + CELL_C;
            end
            if (at_stop)
                stop_ok_r <= above;
        end
    end

    // table walk and report
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            idx_r       <= '0;
            res_valid_r <= 1'b0;
            res_r       <= '0;
            busy_r      <= 1'b0;
        end
        else
        begin
            res_valid_r <= 1'b0;
            busy_r      <= state_r != ST_IDLE;
            if (state_r == ST_LINE && line_end)
            begin
                idx_r <= '0;
                if (code_ok && pre_bad_r)
                begin
                    res_valid_r    <= 1'b1;
                    res_r.found    <= 1'b0;
                    res_r.rejected <= 1'b1;
                    res_r.number   <= code_r;
                    res_r.label    <= '0;
                end
            end
            else if (state_r == ST_SEARCH)
            begin
                idx_r <= idx_r + 1'b1;
                if (hit || last_idx)
                begin
                    res_valid_r    <= 1'b1;
                    res_r.found    <= hit;
                    res_r.rejected <= 1'b0;
                    res_r.number   <= code_r;
                    res_r.label    <= hit ? tbl_lbl[idx_r]
                                          : vsid_pkg::NOT_FOUND_TXT;
                end
            end
        end
    end
endmodule // vsid_decoder

// ---- verif/vsid_decoder_monitor.sv ----
// port assertions for the source id decoder
`timescale 1ns/1ps
module vsid_decoder_monitor #(
    parameter int SAMPLE_W = 10,
    parameter int DEPTH    = 64,
    parameter int ADDR_W   = $clog2(DEPTH)
) (
    input wire logic                   clock,
    input wire logic                   rstn,
    input wire logic [SAMPLE_W-1:0]    sample,
    input wire logic [SAMPLE_W-1:0]    blank_level,
    input wire logic [SAMPLE_W-1:0]    bar_amp,
    input wire logic                   hsync_lead,
    input wire logic [9:0]             line_num,
    input wire vsid_pkg::vsid_cfg_s    cfg,
    input wire logic                   tbl_we,
    input wire logic [ADDR_W-1:0]      tbl_addr,
    input wire vsid_pkg::vsid_entry_s  tbl_entry,
    input wire logic                   res_valid_r,
    input wire vsid_pkg::vsid_result_s res_r,
    input wire logic                   busy_r
);
    logic [9:0]  id_eff;
    logic [5:0]  nb_raw;
    logic [5:0]  nb;
    logic        cap;
    logic [10:0] since_r;
    assign id_eff = cfg.id_line == 10'h000 ? 10'h010 : cfg.id_line;
    assign cap    = hsync_lead && line_num == id_eff && !busy_r;
    // cells that fit between start and stop markers
    assign nb_raw = 6'h1B - {1'b0, cfg.start_us[5:1]};
    assign nb     = (cfg.start_us[0] || cfg.start_us < 6'h1A ||
                     cfg.start_us > 6'h34 || nb_raw > 6'h0E) ? 6'h0E : nb_raw;
    // saturates so a stale count never wraps into the result window
    always_ff @(posedge clock or negedge rstn)
        if (!rstn)
            since_r <= 11'h7FF;
        else if (cap)
            since_r <= 11'h000;
        else if (since_r != 11'h7FF)
            since_r <= since_r + 11'h001;
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence cap_s; cap; endsequence
    sequence on_line_s; ##2 busy_r [*8]; endsequence
    busy_line_a: assert property (cap_s |-> on_line_s)
        else $error("busy did not follow capture");
    other_line_a: assert property (
        hsync_lead && line_num != id_eff && !busy_r |-> ##2 !busy_r)
        else $error("wrong line was captured");
    res_hold_a: assert property (!res_valid_r |-> $stable(res_r))
        else $error("result changed without strobe");
    one_cycle_a: assert property (res_valid_r |=> !res_valid_r)
        else $error("result strobe too long");
    reject_clear_a: assert property (
        res_valid_r && res_r.rejected |-> !res_r.found && res_r.label == '0)
        else $error("rejected result carries a label");
    not_found_a: assert property (
        res_valid_r && !res_r.found && !res_r.rejected
        |-> res_r.label == vsid_pkg::NOT_FOUND_TXT)
        else $error("missing not-found text");
    upper_zero_a: assert property (
        res_valid_r |-> (res_r.number >> nb) == 14'h0000)
        else $error("bits beyond the last cell set");
    stop_time_a: assert property (
        res_valid_r |-> since_r >= 11'h234 && since_r <= 11'(575 + DEPTH))
        else $error("result outside its window");
endmodule // vsid_decoder_monitor

// ---- verif/vsid_inserter.sv ----
// stand-in inserter: puts the id pulse train on each line
`timescale 1ns/1ps
module vsid_inserter (
    input  wire logic                clock,
    input  wire logic                rstn,
    input  wire logic                go,
    input  wire vsid_pkg::vsid_num_t num,
    input  wire logic [5:0]          start_us,
    input  wire logic                junk,
    input  wire logic                stop_on,
    output logic [9:0]               sample
);
    logic [9:0] pos_r;
    logic [9:0] st;
    logic [9:0] rel;
    logic       hi;
    // pos_r is the sample index seen at the next edge; 0 means idle
    always_ff @(posedge clock or negedge rstn)
        if (!rstn)
            pos_r <= 10'h000;
        else if (go)
            pos_r <= 10'h001;
        else if (pos_r != 10'h000 && pos_r != 10'h3FF)
            pos_r <= pos_r + 10'h001;
    assign st  = 10'(start_us * 10);
    assign rel = pos_r - st;
    always_comb
    begin
        hi = junk && pos_r == 10'h00A;
        if (pos_r >= st && pos_r < 10'h230)
            hi = hi || rel < 10'h00A || (rel % 20 < 10 && rel / 20 <= 14
                 && num[rel / 20 - 1]);
        if (stop_on && pos_r >= 10'h230 && pos_r < 10'h23A)
            hi = 1'b1;
    end
    // a driven line: blanking between pulses, never left floating
    assign sample = hi ? 10'h240 : 10'h040;
endmodule // vsid_inserter

// ---- verif/tb_top.sv ----
// self-checking bench for the source id decoder
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin miscompares++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
    logic                   clock, rstn, hsync_lead, tbl_we, junk, stop_on;
    logic                   res_valid_r, busy_r;
    logic [9:0]             sample, line_num;
    logic [5:0]             tbl_addr, ins_start;
    vsid_pkg::vsid_num_t    ins_num;
    vsid_pkg::vsid_cfg_s    cfg;
    vsid_pkg::vsid_entry_s  tbl_entry;
    vsid_pkg::vsid_result_s res_r;
    vsid_pkg::vsid_num_t    tnum [4];
    vsid_pkg::vsid_label_t  tlab [4];
    int                     miscompares = 0;
    int                     checked = 0;
    vsid_decoder vsid_decoder_inst (.clock(clock), .rstn(rstn),
        .sample(sample), .blank_level(10'h040), .bar_amp(10'h200),
        .hsync_lead(hsync_lead), .line_num(line_num), .cfg(cfg),
        .tbl_we(tbl_we), .tbl_addr(tbl_addr), .tbl_entry(tbl_entry),
        .res_valid_r(res_valid_r), .res_r(res_r), .busy_r(busy_r));
    vsid_inserter vsid_inserter_inst (.clock(clock), .rstn(rstn),
        .go(hsync_lead), .num(ins_num), .start_us(ins_start), .junk(junk),
        .stop_on(stop_on), .sample(sample));
    task automatic end_sim;
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [5:0] eff_start(logic [5:0] s);
        return (s[0] || s < 6'h1A || s > 6'h34) ? 6'h1A : s;
    endfunction
    function automatic vsid_pkg::vsid_result_s expect_res(
        vsid_pkg::vsid_num_t n, logic [5:0] s, logic j);
        vsid_pkg::vsid_result_s r;
        int nb;
        r = '0;
        nb = 27 - eff_start(s) / 2;
        if (nb > vsid_pkg::ID_BITS)
            nb = vsid_pkg::ID_BITS;
        r.number = n & 14'((1 << nb) - 1);
        r.rejected = j;
        r.label = j ? '0 : vsid_pkg::NOT_FOUND_TXT;
        for (int i = 3; i >= 0; i--)
            if (!j && tnum[i] === r.number)
            begin
                r.found = 1'b1;
                r.label = tlab[i];
            end
        return r;
    endfunction
    task automatic write_ent(int i, vsid_pkg::vsid_num_t n,
                             vsid_pkg::vsid_label_t l);
        tnum[i] = n;
        tlab[i] = l;
        @(posedge clock);
        tbl_we <= 1'b1;
        tbl_addr <= 6'(i);
        tbl_entry <= {1'b1, n, l};
        @(posedge clock);
        tbl_we <= 1'b0;
    endtask
    task automatic run_line(vsid_pkg::vsid_num_t n, logic [5:0] s, logic j,
                            logic stp, logic [9:0] ln, logic [9:0] idl);
        logic hit;
        logic want;
        hit = 1'b0;
        want = stp && ln == (idl == 10'h000 ? 10'h010 : idl);
        @(posedge clock);
        cfg <= '{id_line: idl, start_us: s};
        {ins_num, ins_start, junk, stop_on} <= {n, eff_start(s), j, stp};
        @(posedge clock);
        hsync_lead <= 1'b1;
        line_num <= ln;
        @(posedge clock);
        hsync_lead <= 1'b0;
        for (int k = 0; k < 700 && !hit; k++)
        begin
            @(negedge clock);
            hit = res_valid_r === 1'b1;
        end
        `CHK("result", want, hit)
        if (hit && want)
            `CHK("fields", expect_res(n, s, j), res_r)
        repeat (4) @(posedge clock);
    endtask
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial
    begin
        #4000000;
        miscompares++;
        end_sim();
    end
    initial
    begin
        {rstn, hsync_lead, tbl_we, junk, stop_on, line_num, tbl_addr, cfg,
         tbl_entry, ins_num, ins_start} = '0;
        void'($urandom(32'h8BF1));
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        `CHK("reset", 178'h0, {res_valid_r, busy_r, res_r})
        write_ent(0, 14'h0000, "ZERO");
        write_ent(1, 14'h3FFF, "TOP");
        write_ent(2, 14'($urandom), "ABCDEFGHIJKLMNOPQRST");
        write_ent(3, 14'h3FFF, "SHADOW");
        run_line(14'h0000, 6'h1A, 1'b0, 1'b1, 10'h010, 10'h000);
        run_line(14'h3FFF, 6'h1A, 1'b0, 1'b1, 10'h010, 10'h000);
        run_line(tnum[2], 6'h1A, 1'b0, 1'b1, 10'h010, 10'h000);
        run_line(14'h3FFF, 6'h34, 1'b0, 1'b1, 10'h010, 10'h000);
        run_line(14'h1555, 6'h1B, 1'b0, 1'b1, 10'h010, 10'h000);
        run_line(14'h2AAA, 6'h3C, 1'b0, 1'b1, 10'h010, 10'h000);
        run_line(14'h0005, 6'h1A, 1'b1, 1'b1, 10'h010, 10'h000);
        run_line(14'h0005, 6'h1A, 1'b0, 1'b0, 10'h010, 10'h000);
        run_line(14'h0005, 6'h1A, 1'b0, 1'b1, 10'h011, 10'h000);
        run_line(tnum[2], 6'h28, 1'b0, 1'b1, 10'h014, 10'h014);
        repeat (14)
            run_line($urandom % 2 ? tnum[$urandom % 3] : 14'($urandom),
                     6'h1A + 6'(2 * ($urandom % 14)), $urandom % 4 == 0,
                     1'b1, 10'h010, 10'h000);
        end_sim();
    end
endmodule // tb_top
bind vsid_decoder vsid_decoder_monitor #(.SAMPLE_W(SAMPLE_W), .DEPTH(DEPTH),
    .ADDR_W(ADDR_W)) vsid_decoder_monitor_inst (.clock(clock), .rstn(rstn),
    .sample(sample), .blank_level(blank_level), .bar_amp(bar_amp),
    .hsync_lead(hsync_lead), .line_num(line_num), .cfg(cfg),
    .tbl_we(tbl_we), .tbl_addr(tbl_addr), .tbl_entry(tbl_entry),
    .res_valid_r(res_valid_r), .res_r(res_r), .busy_r(busy_r));
